// >>> rtl/isb_pkg.sv
// Constants and types shared by the interlocked bus slave port
package isb_pkg;
	// ------------------------------------------------------------
	// Bus widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int REQ_W = 4;
	localparam int REG_COUNT = 4;
	localparam int IDX_W = 2;
	// ------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------
	localparam logic [17:0] IO_BASE = 18'h3E000; // Peripheral page, octal 760000
	localparam logic [17:0] DEV_BASE = 18'h3FF00; // Our four words, octal 777400
	localparam logic [17:0] DEV_MASK = 18'h3FFF8; // Four words, eight bytes
	localparam int IDX_LSB = 1;
	localparam int BYTE_SEL_BIT = 0;
	// ------------------------------------------------------------
	// Transfer codes and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] XFER_WORD_READ = 2'h0;
	localparam logic [1:0] XFER_READ_WITH_PAUSE = 2'h1;
	localparam logic [1:0] XFER_WORD_WRITE = 2'h2;
	localparam logic [1:0] XFER_BYTE_WRITE = 2'h3;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [17:0] ADDR_RESET = 18'h00000;
	// ------------------------------------------------------------
	// Slave sequencer states, Gray coded in listed order; REPLY to IDLE and ACCESS to RELEASE change both bits
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ACCESS = 2'h1,
		ST_REPLY = 2'h3,
		ST_RELEASE = 2'h2
	} isb_state_e;
endpackage

// >>> rtl/isb_reg_bank.sv
// Peripheral word registers reached through the bus slave port
module isb_reg_bank
	import isb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic busWrEn,
	input wire logic busByte,
	input wire logic busHighByte,
	input wire logic [IDX_W-1:0] busIdx,
	input wire logic [DATA_W-1:0] busWrData,
	input wire logic userWrEn,
	input wire logic [IDX_W-1:0] userIdx,
	input wire logic [DATA_W-1:0] userWrData,
	output logic [DATA_W-1:0] rdWord,
	output logic [REG_COUNT*DATA_W-1:0] wordsFlat
);
	typedef struct packed {
		logic [REG_COUNT-1:0][DATA_W-1:0] words;
	} isb_bank_s;

	isb_bank_s bank_reg;
	isb_bank_s bank_next;

	// ------------------------------------------------------------
	// Write merge: bus wins over user so a master never sees a lost write
	// ------------------------------------------------------------
	always_comb begin
		bank_next = bank_reg;
		if (userWrEn) begin
			bank_next.words[userIdx] = userWrData;
		end
		if (busWrEn) begin
			if (!busByte) begin
				bank_next.words[busIdx] = busWrData;
			end else if (busHighByte) begin
				bank_next.words[busIdx][15:8] = busWrData[15:8];
			end else begin
				bank_next.words[busIdx][7:0] = busWrData[7:0];
			end
		end
	end

	// Register stage, frozen while the enable is low
	always_ff @(posedge clk) begin
		if (rst) begin
			bank_reg <= '0;
		end else if (ce) begin
			bank_reg <= bank_next;
		end
	end

	// Read path and user view
	assign rdWord = bank_reg.words[busIdx];
	assign wordsFlat = bank_reg.words;
endmodule // isb_reg_bank

// >>> rtl/isb_slave_port.sv
// Slave side of the interlocked bus: decode, handshake, data and parity
module isb_slave_port
	import isb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] addrInN,
	input wire logic [1:0] ctrlInN,
	input wire logic masterSyncStrobeInN,
	input wire logic slaveSyncReplyInN,
	output logic slaveSyncReplyOutN,
	output logic slaveSyncReplyOe,
	input wire logic [DATA_W-1:0] dataInN,
	output logic [DATA_W-1:0] dataOutN,
	output logic [DATA_W-1:0] dataOe,
	input wire logic highByteParityInN,
	output logic highByteParityOutN,
	output logic highByteParityOe,
	input wire logic lowByteParityInN,
	output logic lowByteParityOutN,
	output logic lowByteParityOe,
	input wire logic [REQ_W-1:0] busRequestInN,
	output logic [REQ_W-1:0] busRequestOutN,
	output logic [REQ_W-1:0] busRequestOe,
	input wire logic busInUseInN,
	output logic busInUseOutN,
	output logic busInUseOe,
	input wire logic initInN,
	input wire logic [REQ_W-1:0] userRequest,
	input wire logic userOwnsBus,
	input wire logic userWrEn,
	input wire logic [IDX_W-1:0] userIdx,
	input wire logic [DATA_W-1:0] userWrData,
	output logic [REG_COUNT*DATA_W-1:0] userWords,
	output logic busWriteStrobe,
	output logic parityError
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		isb_state_e state;
		logic [1:0] ctrl;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] rdData;
		logic [DATA_W-1:0] wrData;
		logic driveData;
		logic reply;
		logic parErr;
		logic wrPulse;
	} isb_port_s;

	isb_port_s port_reg;
	isb_port_s port_next;

	logic syncA;
	logic initA;
	logic selected;
	logic isRead;
	logic [DATA_W-1:0] bankWord;
	logic [DATA_W-1:0] dataA;
	logic hiParA;
	logic loParA;

	// Receivers invert the active-low wire levels to asserted-high
	assign syncA = !masterSyncStrobeInN;
	assign initA = !initInN;
	assign dataA = ~dataInN;
	assign hiParA = !highByteParityInN;
	assign loParA = !lowByteParityInN;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Ours only if inside the peripheral page and our eight bytes
	function automatic logic addrIsMine(input logic [ADDR_W-1:0] a);
		addrIsMine = (a >= IO_BASE) && ((a & DEV_MASK) == DEV_BASE);
	endfunction

	// Both read codes move data from slave to master
	function automatic logic codeIsRead(input logic [1:0] c);
		codeIsRead = (c == XFER_WORD_READ) || (c == XFER_READ_WITH_PAUSE);
	endfunction

	assign selected = addrIsMine(port_reg.addr);
	assign isRead = codeIsRead(port_reg.ctrl);

	// ------------------------------------------------------------
	// Register bank
	// ------------------------------------------------------------
	// Initialise clears the bank only on an enabled edge, so a low enable still freezes it
	isb_reg_bank isb_reg_bank_inst (
		.clk(clk),
		.rst(rst || (initA && ce)),
		.ce(ce),
		.busWrEn(port_reg.state == ST_ACCESS && selected && !isRead),
		.busByte(port_reg.ctrl == XFER_BYTE_WRITE),
		.busHighByte(port_reg.addr[BYTE_SEL_BIT]),
		.busIdx(port_reg.addr[IDX_LSB +: IDX_W]),
		.busWrData(port_reg.wrData),
		.userWrEn(userWrEn),
		.userIdx(userIdx),
		.userWrData(userWrData),
		.rdWord(bankWord),
		.wordsFlat(userWords)
	);

	// ------------------------------------------------------------
	// Sequencer: strobe, access, reply, wait for strobe release
	// ------------------------------------------------------------
	always_comb begin
		port_next = port_reg;
		port_next.parErr = 1'b0;
		port_next.wrPulse = 1'b0;
		unique case (port_reg.state)
			ST_IDLE: begin
				// Address, code and write data are valid when the strobe rises
				if (syncA) begin
					port_next.addr = ~addrInN;
					port_next.ctrl = ~ctrlInN;
					port_next.wrData = dataA;
					port_next.parErr = 1'b0;
					port_next.state = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				if (!selected) begin
					port_next.state = ST_RELEASE;
				end else begin
					// Word done in this cycle, so the reply may follow
					port_next.reply = 1'b1;
					port_next.state = ST_REPLY;
					if (isRead) begin
						port_next.rdData = bankWord;
						port_next.driveData = 1'b1;
					end else begin
						port_next.wrPulse = 1'b1;
						// Check only the lanes actually written
						if (port_reg.ctrl == XFER_WORD_WRITE || port_reg.addr[BYTE_SEL_BIT]) begin
							port_next.parErr = (^port_reg.wrData[15:8]) != hiParA;
						end
						if (port_reg.ctrl == XFER_WORD_WRITE || !port_reg.addr[BYTE_SEL_BIT]) begin
							port_next.parErr = port_next.parErr || ((^port_reg.wrData[7:0]) != loParA);
						end
					end
				end
			end
			ST_REPLY: begin
				// Interlock: reply stays until the master drops its strobe
				if (!syncA) begin
					port_next.reply = 1'b0;
					port_next.driveData = 1'b0;
					port_next.state = ST_IDLE;
				end
			end
			ST_RELEASE: begin
				// Not ours: sit out the cycle so a late strobe edge is not reused
				if (!syncA) begin
					port_next.state = ST_IDLE;
				end
			end
		endcase
	end

	// Register stage; initialise clears like reset
	always_ff @(posedge clk) begin
		if (rst) begin
			port_reg <= '0;
		end else if (ce) begin
			if (initA) begin
				port_reg <= '0;
			end else begin
				port_reg <= port_next;
			end
		end
	end

	// ------------------------------------------------------------
	// Open-collector drivers: only pull low, never drive high
	// ------------------------------------------------------------
	assign slaveSyncReplyOutN = 1'b0;
	assign slaveSyncReplyOe = port_reg.reply;
	assign dataOutN = '0;
	assign dataOe = port_reg.driveData ? port_reg.rdData : '0;
	assign highByteParityOutN = 1'b0;
	assign highByteParityOe = port_reg.driveData && (^port_reg.rdData[15:8]);
	assign lowByteParityOutN = 1'b0;
	assign lowByteParityOe = port_reg.driveData && (^port_reg.rdData[7:0]);
	assign busRequestOutN = '0;
	assign busRequestOe = initA ? '0 : userRequest;
	// Only held while our own master logic owns the bus
	assign busInUseOutN = 1'b0;
	assign busInUseOe = userOwnsBus && !initA;
	assign busWriteStrobe = port_reg.wrPulse;
	assign parityError = port_reg.parErr;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_replyOnlyWhenMine;
		@(posedge clk) disable iff (rst || initA || !ce)
		$rose(slaveSyncReplyOe) |-> $past(port_reg.state) == ST_ACCESS && addrIsMine($past(port_reg.addr));
	endproperty
	a_replyOnlyWhenMine: assert property (p_replyOnlyWhenMine) else $error("reply for foreign address");

	property p_replyHeld;
		@(posedge clk) disable iff (rst || initA || !ce)
		slaveSyncReplyOe && syncA |=> slaveSyncReplyOe;
	endproperty
	a_replyHeld: assert property (p_replyHeld) else $error("reply dropped while strobe held");

	property p_replyReleased;
		@(posedge clk) disable iff (rst || initA || !ce)
		slaveSyncReplyOe && !syncA |=> !slaveSyncReplyOe && !(|dataOe);
	endproperty
	a_replyReleased: assert property (p_replyReleased) else $error("reply not released");

	property p_replyTiming;
		@(posedge clk) disable iff (rst || initA || !ce)
		port_reg.state == ST_IDLE && syncA && addrIsMine(~addrInN) ##1 ce |=> slaveSyncReplyOe;
	endproperty
	a_replyTiming: assert property (p_replyTiming) else $error("reply not two cycles after strobe");

	property p_foreignIgnored;
		@(posedge clk) disable iff (rst || initA || !ce)
		port_reg.state == ST_ACCESS && !selected |=> port_reg.state == ST_RELEASE && !slaveSyncReplyOe;
	endproperty
	a_foreignIgnored: assert property (p_foreignIgnored) else $error("foreign access answered");

	property p_readDrivesData;
		@(posedge clk) disable iff (rst || initA || !ce)
		port_reg.state == ST_ACCESS && selected |=> port_reg.driveData == codeIsRead($past(port_reg.ctrl));
	endproperty
	a_readDrivesData: assert property (p_readDrivesData) else $error("data drive does not match code");

	property p_parityLines;
		@(posedge clk) disable iff (rst)
		highByteParityOe == (^dataOe[15:8]) && lowByteParityOe == (^dataOe[7:0]);
	endproperty
	a_parityLines: assert property (p_parityLines) else $error("parity lines wrong");

	property p_initClears;
		@(posedge clk) disable iff (rst || !ce)
		initA |=> port_reg.state == ST_IDLE && !slaveSyncReplyOe && !(|dataOe);
	endproperty
	a_initClears: assert property (p_initClears) else $error("initialise did not clear port");

	property p_openCollector;
		@(posedge clk) disable iff (rst)
		!slaveSyncReplyOutN && !(|dataOutN) && !(|busRequestOutN) && !busInUseOutN;
	endproperty
	a_openCollector: assert property (p_openCollector) else $error("driver drives high");

	property p_writePulse;
		@(posedge clk) disable iff (rst || initA || !ce)
		busWriteStrobe |-> slaveSyncReplyOe && !port_reg.driveData && $past(port_reg.state) == ST_ACCESS;
	endproperty
	a_writePulse: assert property (p_writePulse) else $error("write strobe out of place");
endmodule // isb_slave_port

// >>> tb/isb_master_model.sv
// Bus master model driving the interlocked bus wires from the far side
module isb_master_model
	import isb_pkg::*;
(
	input wire logic clk,
	input wire logic replyN,
	input wire logic [DATA_W-1:0] dataN,
	input wire logic hiN,
	input wire logic loN,
	output logic [ADDR_W-1:0] addrN,
	output logic [1:0] ctrlN,
	output logic strobeN,
	output logic [DATA_W-1:0] dOe,
	output logic hiOe,
	output logic loOe,
	output logic rdDone,
	output logic [17:0] rdVal
);
	timeunit 1ns;
	timeprecision 100ps;
	// Released lines float to the pull-up, which reads as deasserted
	task automatic idle();
		addrN = '1;
		ctrlN = '1;
		strobeN = 1'b1;
		dOe = '0;
		hiOe = 1'b0;
		loOe = 1'b0;
	endtask
	initial begin
		idle();
		rdDone = 1'b0;
		rdVal = '0;
	end
	// One transfer; bad flips the high parity, hold keeps the strobe longer
	task automatic xfer(input logic [17:0] a, input logic [1:0] c, input logic [15:0] d,
		input logic bad, input int hold, output logic ok);
		int n;
		logic up;
		ok = 1'b0;
		up = 1'b0;
		@(negedge clk);
		addrN = ~a;
		ctrlN = ~c;
		if (c[1]) begin
			dOe = d;
			hiOe = ^d[15:8] ^ bad;
			loOe = ^d[7:0];
		end
		// Strobe only a cycle after address and code settle
		@(negedge clk);
		strobeN = 1'b0;
		for (n = 0; n < 12 && !ok; n++) begin
			@(negedge clk);
			ok = !replyN;
		end
		if (ok && !c[1]) begin
			rdVal = {~hiN, ~loN, ~dataN};
			rdDone = 1'b1;
		end
		// A slow master: the reply has to keep standing meanwhile
		for (n = 0; n < hold; n++) begin
			@(negedge clk);
			rdDone = 1'b0;
			ok = ok & !replyN;
		end
		@(negedge clk);
		rdDone = 1'b0;
		strobeN = 1'b1;
		for (n = 0; n < 6 && !up; n++) begin
			@(negedge clk);
			up = replyN;
		end
		ok = ok & up;
		idle();
	endtask
endmodule // isb_master_model

// >>> tb/interlocked_bus_slave_port_tb.sv
// Self-checking bench for the interlocked bus slave port
module interlocked_bus_slave_port_tb
	import isb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst, ce, initN, userOwnsBus, userWrEn, strobeN, hiOe, loOe, mHiOe, mLoOe, rdDone;
	logic replyOe, busWriteStrobe, parityError, busInUseOe, ok;
	logic replyOutN, hiOutN, loOutN, inUseOutN;
	logic [1:0] ctrlN, userIdx;
	logic [3:0] userRequest, busRequestOe, reqOutN;
	logic [15:0] userWrData, dataOe, mDataOe, d, dataOutN;
	logic [17:0] addrN, rdVal;
	logic [19:0] x;
	logic [63:0] userWords;
	logic [15:0] mem [4];
	logic [19:0] expQ [$];
	logic [17:0] foreign [4] = '{DEV_BASE + 18'h8, IO_BASE, ADDR_RESET, DEV_BASE - 18'h2};
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int seed = 32'hAA09BC65;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	// Wired lines: pulled up, low while any party pulls them
	isb_slave_port isb_slave_port_inst (.clk(clk), .rst(rst), .ce(ce), .addrInN(addrN), .ctrlInN(ctrlN),
		.masterSyncStrobeInN(strobeN), .slaveSyncReplyInN(~replyOe), .slaveSyncReplyOutN(replyOutN),
		.slaveSyncReplyOe(replyOe), .dataInN(~(dataOe | mDataOe)), .dataOutN(dataOutN), .dataOe(dataOe),
		.highByteParityInN(~(hiOe | mHiOe)), .highByteParityOutN(hiOutN), .highByteParityOe(hiOe),
		.lowByteParityInN(~(loOe | mLoOe)), .lowByteParityOutN(loOutN), .lowByteParityOe(loOe),
		.busRequestInN(~busRequestOe), .busRequestOutN(reqOutN), .busRequestOe(busRequestOe),
		.busInUseInN(~busInUseOe), .busInUseOutN(inUseOutN), .busInUseOe(busInUseOe), .initInN(initN),
		.userRequest(userRequest), .userOwnsBus(userOwnsBus), .userWrEn(userWrEn), .userIdx(userIdx),
		.userWrData(userWrData), .userWords(userWords), .busWriteStrobe(busWriteStrobe),
		.parityError(parityError));
	isb_master_model isb_master_model_inst (.clk(clk), .replyN(~replyOe), .dataN(~(dataOe | mDataOe)),
		.hiN(~(hiOe | mHiOe)), .loN(~(loOe | mLoOe)), .addrN(addrN), .ctrlN(ctrlN), .strobeN(strobeN),
		.dOe(mDataOe), .hiOe(mHiOe), .loOe(mLoOe), .rdDone(rdDone), .rdVal(rdVal));
	task automatic chk(input string what, input logic [63:0] e, input logic [63:0] s);
		n_compared++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", what, e, s);
			fail_count++;
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Bus write: only the written lane merges into the shadow word
	task automatic wr(input logic [17:0] a, input logic [1:0] c, input logic [15:0] v, input logic bad, input int h);
		logic [1:0] i;
		i = a[2:1];
		if (c == XFER_WORD_WRITE) mem[i] = v;
		else if (a[0]) mem[i][15:8] = v[15:8];
		else mem[i][7:0] = v[7:0];
		expQ.push_back({i, 1'b0, bad & (c == XFER_WORD_WRITE | a[0]), mem[i]});
		isb_master_model_inst.xfer(a, c, v, bad, h, ok);
		chk("write reply", 1, ok);
	endtask
	task automatic rd(input logic [17:0] a, input logic [1:0] c, input int h);
		logic [15:0] e;
		e = mem[a[2:1]];
		expQ.push_back({a[2:1], ^e[15:8], ^e[7:0], e});
		isb_master_model_inst.xfer(a, c, 16'h0000, 1'b0, h, ok);
		chk("read reply", 1, ok);
	endtask
	// Oldest note is matched once the outputs have settled
	always @(posedge clk) begin
		#1;
		if (busWriteStrobe === 1'b1 || rdDone === 1'b1) begin
			x = expQ.pop_front();
			if (rdDone) chk("read data", x[17:0], rdVal);
			else chk("write word", x[17:0], {1'b0, parityError, userWords[16*x[19:18] +: 16]});
		end
	end
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		{rst, ce, initN, userOwnsBus, userWrEn} = 5'b11100;
		{userRequest, userIdx, userWrData} = '0;
		mem = '{default: WORD_RESET};
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk("reset", 0, {userWords[31:0], replyOe, hiOe, loOe, dataOe});
		for (int k = 0; k < 12; k++) begin
			d = 16'($random(seed));
			wr(DEV_BASE | 18'($random(seed) & 7), k[0] ? XFER_BYTE_WRITE : XFER_WORD_WRITE, d, 1'b0, k % 3);
		end
		// Bad high parity flags only where that lane is written
		wr(DEV_BASE | 18'h3, XFER_BYTE_WRITE, 16'h01FE, 1'b1, 0);
		wr(DEV_BASE | 18'h2, XFER_BYTE_WRITE, 16'h5A3C, 1'b1, 0);
		wr(DEV_BASE | 18'h4, XFER_WORD_WRITE, 16'hF00D, 1'b1, 1);
		for (int k = 0; k < 8; k++) rd(DEV_BASE | 18'(k), k[0] ? XFER_READ_WITH_PAUSE : XFER_WORD_READ, k % 2);
		$display("test bus transfers done");
		foreach (foreign[k]) begin
			isb_master_model_inst.xfer(foreign[k], XFER_WORD_WRITE, 16'hFFFF, 1'b0, 0, ok);
			chk("foreign reply", 0, ok);
		end
		chk("words", {mem[3], mem[2], mem[1], mem[0]}, userWords);
		$display("test foreign addresses done");
		// Frozen clock enable holds the user write back
		{ce, userWrEn, userIdx, userWrData} = {2'b01, 2'h2, 16'hA5C3};
		@(negedge clk);
		chk("frozen", {mem[3], mem[2], mem[1], mem[0]}, userWords);
		ce = 1'b1;
		@(negedge clk);
		userWrEn = 1'b0;
		mem[2] = 16'hA5C3;
		chk("user write", {mem[3], mem[2], mem[1], mem[0]}, userWords);
		rd(DEV_BASE | 18'h4, XFER_WORD_READ, 0);
		$display("test user write done");
		userRequest = 4'($random(seed)) | 4'h1;
		userOwnsBus = 1'b1;
		#1;
		chk("requests", {userRequest, 1'b1}, {busRequestOe, busInUseOe});
		chk("open collector", 0, {replyOutN, dataOutN, hiOutN, loOutN, reqOutN, inUseOutN});
		initN = 1'b0;
		@(negedge clk);
		chk("init lines", 0, {busRequestOe, busInUseOe});
		chk("init words", 0, userWords);
		initN = 1'b1;
		mem = '{default: WORD_RESET};
		rd(DEV_BASE | 18'h6, XFER_WORD_READ, 2);
		chk("notes left", 0, expQ.size());
		$display("test init done");
		end_of_test();
	end
endmodule // interlocked_bus_slave_port_tb
